// ---- design/fcs_pkg.sv ----
package fcs_pkg;
    localparam int          FCS_ADDR_W        = 4;
    localparam logic [3:0]  FCS_OFF_STATUS    = 4'h6;
    localparam logic [3:0]  FCS_OFF_CONFIG    = 4'h4;
    localparam logic [3:0]  FCS_OFF_IRQ_STAT  = 4'h8;
    localparam logic [3:0]  FCS_OFF_IRQ_MASK  = 4'h9;
    localparam int          FCS_BIT_DONE      = 7;
    localparam int          FCS_BIT_ACCESS_ERROR_FLAG    = 5;
    localparam int          FCS_BIT_PROTV     = 4;
    localparam int          FCS_BIT_BUSY      = 3;
    localparam int          FCS_RES_HI        = 1;
    localparam int          FCS_RES_LO        = 0;
    localparam int          FCS_BIT_IRQ_EN    = 7;
    localparam int          FCS_EV_DONE       = 0;
    localparam int          FCS_EV_ACCESS_ERROR_FLAG     = 1;
    localparam int          FCS_EV_PROTV      = 2;
    localparam int          FCS_EV_RESULT     = 3;
    localparam int          FCS_EV_W          = 4;
    localparam logic [1:0]  FCS_RESULT_RESET  = 2'h0;
    localparam logic [1:0]  FCS_RESULT_DBLFLT = 2'h3;
    localparam int          FCS_EXEC_CYCLES   = 16;
endpackage

// ---- design/fcs_exec_timer.sv ----
`timescale 1ns/1ps
module fcs_exec_timer
    import fcs_pkg::*;
#(
    parameter int CYCLES = FCS_EXEC_CYCLES
)
(
    input  wire logic sys_clk,
    input  wire logic rstSync_n,
    input  wire logic start,
    output logic      running,
    output logic      finished
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count;

    initial
    begin
        if (CYCLES < 1) $error("CYCLES must be at least one");
    end

    always_ff @(posedge sys_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            count    <= '0;
            running  <= 1'b0;
            finished <= 1'b0;
        end
        else
        begin
            finished <= 1'b0;
            if (start && !running)
            begin
                count   <= CW'(CYCLES - 1);
                running <= 1'b1;
            end
            else if (running)
            begin
                if (count == '0)
                begin
                    running  <= 1'b0;
                    finished <= 1'b1;
                end
                else
                    count <= count - 1'b1;
            end
        end
    end
endmodule // fcs_exec_timer

// ---- design/fcs_flash_command_status.sv ----
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module fcs_flash_command_status
    import fcs_pkg::*;
#(
    parameter int EXEC_CYCLES = FCS_EXEC_CYCLES
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic [FCS_ADDR_W-1:0] regAddr,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regWrStrobe,
    input  wire logic                  regRdStrobe,
    output logic      [7:0]            regRdData,
    input  wire logic                  seqWrite,
    input  wire logic                  seqViolation,
    input  wire logic                  illegalCommand,
    input  wire logic                  protectedTarget,
    input  wire logic                  execError,
    input  wire logic                  resetSeqDone,
    input  wire logic                  resetSeqFault,
    output logic                       seqAccept,
    output logic                       cmdLaunch,
    output logic                       irq
);
    logic       rstMeta_n;
    logic       rstSync_n;
    logic       commandDone;
    logic       accessError;
    logic       protectViolation;
    logic [1:0] commandResult;
    logic       doneIrqEnable;
    logic [FCS_EV_W-1:0] eventStatus;
    logic [FCS_EV_W-1:0] eventMask;
    logic       controllerBusy;
    logic       execFinished;
    logic       wrStatus;
    logic       launchReq;
    logic       accErrSet;
    logic       protSet;
    logic [7:0] statusView;

    initial
    begin
        if (EXEC_CYCLES < 1) $error("EXEC_CYCLES must be at least one");
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end
        else
        begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    assign wrStatus  = regWrStrobe && regAddr == FCS_OFF_STATUS;
    // A launch needs both error flags clear and no command already running
    assign launchReq = wrStatus && regWrData[FCS_BIT_DONE] && commandDone
                       && !accessError && !protectViolation;
    assign cmdLaunch = launchReq;
    assign seqAccept = seqWrite && commandDone && !protectViolation;
    assign accErrSet = seqViolation || illegalCommand
                       || (wrStatus && regWrData[FCS_BIT_DONE] && !commandDone);
    assign protSet   = seqWrite && protectedTarget && commandDone;

    fcs_exec_timer #(
        .CYCLES (EXEC_CYCLES)
    ) u_timer (
        .sys_clk   (sys_clk),
        .rstSync_n (rstSync_n),
        .start     (launchReq),
        .running   (controllerBusy),
        .finished  (execFinished)
    );

    always_ff @(posedge sys_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            commandDone <= 1'b1;
        else if (launchReq)
            commandDone <= 1'b0;
        else if (execFinished)
            commandDone <= 1'b1;
    end

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge sys_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            accessError <= 1'b0;
        else if (accErrSet)
            accessError <= 1'b1;
        else if (wrStatus && regWrData[FCS_BIT_ACCESS_ERROR_FLAG])
            accessError <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            protectViolation <= 1'b0;
        else if (protSet)
            protectViolation <= 1'b1;
        else if (wrStatus && regWrData[FCS_BIT_PROTV])
            protectViolation <= 1'b0;
    end

    // Result field only changes by hardware or a launch write, which clears it; other writes never touch it
    always_ff @(posedge sys_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            commandResult <= FCS_RESULT_RESET;
        else if (resetSeqDone && resetSeqFault)
            commandResult <= FCS_RESULT_DBLFLT;
        else if (launchReq)
            commandResult <= FCS_RESULT_RESET;
        else if (controllerBusy && execError)
            commandResult[FCS_RES_LO] <= 1'b1;
        else if (resetSeqDone && execError)
            commandResult[FCS_RES_HI] <= 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            doneIrqEnable <= 1'b0;
        else if (regWrStrobe && regAddr == FCS_OFF_CONFIG)
            doneIrqEnable <= regWrData[FCS_BIT_IRQ_EN];
    end

    always_ff @(posedge sys_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            eventMask <= '0;
        else if (regWrStrobe && regAddr == FCS_OFF_IRQ_MASK)
            eventMask <= regWrData[FCS_EV_W-1:0];
    end

    always_ff @(posedge sys_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            eventStatus <= '0;
        else
        begin
            for (int i = 0; i < FCS_EV_W; i++)
            begin
                if ((regWrStrobe && regAddr == FCS_OFF_IRQ_STAT && regWrData[i]))
                    eventStatus[i] <= 1'b0;
                if (i == FCS_EV_DONE && execFinished)
                    eventStatus[i] <= 1'b1;
                if (i == FCS_EV_ACCESS_ERROR_FLAG && accErrSet)
                    eventStatus[i] <= 1'b1;
                if (i == FCS_EV_PROTV && protSet)
                    eventStatus[i] <= 1'b1;
                if (i == FCS_EV_RESULT && controllerBusy && execError)
                    eventStatus[i] <= 1'b1;
            end
        end
    end

    // Done interrupt is a level while the flag stays set
    assign irq = (doneIrqEnable && commandDone) || |(eventStatus & eventMask);

    always_comb
    begin
        statusView                = 8'h00;
        statusView[FCS_BIT_DONE]  = commandDone;
        statusView[FCS_BIT_ACCESS_ERROR_FLAG] = accessError;
        statusView[FCS_BIT_PROTV] = protectViolation;
        statusView[FCS_BIT_BUSY]  = controllerBusy;
        statusView[FCS_RES_HI:FCS_RES_LO] = commandResult;
    end

    always_ff @(posedge sys_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            regRdData <= 8'h00;
        else if (regRdStrobe)
        begin
            unique case (regAddr)
                FCS_OFF_STATUS:   regRdData <= statusView;
                FCS_OFF_CONFIG:   regRdData <= {doneIrqEnable, 7'h00};
                FCS_OFF_IRQ_STAT: regRdData <= {4'h0, eventStatus};
                FCS_OFF_IRQ_MASK: regRdData <= {4'h0, eventMask};
                default:          regRdData <= 8'h00;
            endcase
        end
        else
            regRdData <= 8'h00;
    end

    sequence s_launch;
        launchReq;
    endsequence

    a_launch_clears_done: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        s_launch |=> !commandDone && controllerBusy)
        else $error("Launch did not clear done flag");
    a_done_after_exec: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        s_launch |-> ##[1:300] commandDone)
        else $error("Command never completed");
    a_access_error_flag_blocks: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        accessError |-> !cmdLaunch)
        else $error("Launch while access error set");
    a_protv_blocks: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        protectViolation |-> !cmdLaunch && !seqAccept)
        else $error("Launch or sequence while protection violation");
    a_access_error_flag_sets: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        (seqViolation || illegalCommand) |=> accessError)
        else $error("Access error not set");
    a_access_error_flag_clear: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        wrStatus && regWrData[FCS_BIT_ACCESS_ERROR_FLAG] && !accErrSet |=> !accessError)
        else $error("Access error not cleared");
    a_protv_sticky: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        protectViolation && !(wrStatus && regWrData[FCS_BIT_PROTV]) |=> protectViolation)
        else $error("Protection violation lost");
    a_busy_done_excl: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        controllerBusy |-> !commandDone)
        else $error("Busy with done flag set");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        $past(regRdStrobe) && $past(regAddr) == FCS_OFF_STATUS |-> regRdData[6] == 1'b0 && regRdData[2] == 1'b0)
        else $error("Reserved status bit read nonzero");
    a_done_irq: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        doneIrqEnable && commandDone |-> irq)
        else $error("Done interrupt missing");
endmodule // fcs_flash_command_status

// ---- verification/fcs_flash_command_status_tb.sv ----
`timescale 1ns/1ps
module fcs_flash_command_status_tb;
    import fcs_pkg::*;
    localparam int EXEC = 2;
    logic                  sys_clk;
    logic                  rst_n;
    logic [FCS_ADDR_W-1:0] regAddr;
    logic [7:0]            regWrData;
    logic                  regWrStrobe;
    logic                  regRdStrobe;
    logic [7:0]            regRdData;
    logic                  seqWrite;
    logic                  seqViolation;
    logic                  illegalCommand;
    logic                  protectedTarget;
    logic                  execError;
    logic                  resetSeqDone;
    logic                  resetSeqFault;
    logic                  seqAccept;
    logic                  cmdLaunch;
    logic                  irq;
    logic                  rdTaken;
    logic                  irqA;
    logic [7:0]            expQ[$];
    int                    errors;
    int                    checksDone;
    fcs_flash_command_status #(.EXEC_CYCLES(EXEC)) fcs_flash_command_status_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .seqWrite(seqWrite), .seqViolation(seqViolation), .illegalCommand(illegalCommand),
        .protectedTarget(protectedTarget), .execError(execError), .resetSeqDone(resetSeqDone),
        .resetSeqFault(resetSeqFault), .seqAccept(seqAccept), .cmdLaunch(cmdLaunch), .irq(irq));
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checksDone++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        regRdStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        regWrStrobe <= 1'b0;
        expQ.push_back(e);
    endtask
    // Strobes and event pulses drop; level inputs are left to the caller
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            regWrStrobe <= 1'b0;
            regRdStrobe <= 1'b0;
            seqWrite <= 1'b0;
            seqViolation <= 1'b0;
            illegalCommand <= 1'b0;
            resetSeqDone <= 1'b0;
            resetSeqFault <= 1'b0;
        end
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken at that edge
    always @(posedge sys_clk)
    begin
        if (rdTaken)
            chk(regRdData, expQ.pop_front(), "read data");
        rdTaken <= regRdStrobe;
    end
    initial
    begin
        #20000;
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
    initial
    begin
        {rst_n, regAddr, regWrData, regWrStrobe, regRdStrobe, rdTaken} = '0;
        {seqWrite, seqViolation, illegalCommand, protectedTarget} = '0;
        {execError, resetSeqDone, resetSeqFault} = '0;
        errors = 0;
        checksDone = 0;
        void'($urandom(32'hdf46));
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(FCS_OFF_STATUS, 8'h80);
        rd(4'hf, 8'h00);
        idle(2);
        #1 chk({7'h00, irq}, 8'h00, "irq after reset");
        $display("test reset values done");
        wr(FCS_OFF_STATUS, 8'h80);
        #1 chk({7'h00, cmdLaunch}, 8'h01, "launch");
        rd(FCS_OFF_STATUS, 8'h08);
        wr(FCS_OFF_STATUS, 8'h80);
        #1 chk({7'h00, cmdLaunch}, 8'h00, "launch while busy");
        idle(EXEC + 4);
        rd(FCS_OFF_STATUS, 8'ha0);
        rd(FCS_OFF_IRQ_STAT, 8'h03);
        wr(FCS_OFF_IRQ_STAT, 8'h03);
        rd(FCS_OFF_IRQ_STAT, 8'h00);
        wr(FCS_OFF_STATUS, 8'h80);
        #1 chk({7'h00, cmdLaunch}, 8'h00, "launch under access error");
        rd(FCS_OFF_STATUS, 8'ha0);
        wr(FCS_OFF_STATUS, 8'($urandom()) & 8'h4f);
        rd(FCS_OFF_STATUS, 8'ha0);
        wr(FCS_OFF_STATUS, 8'h20);
        rd(FCS_OFF_STATUS, 8'h80);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk);
            // The previous read strobe must last only one cycle
            regRdStrobe <= 1'b0;
            seqViolation <= (i == 0);
            illegalCommand <= (i == 1);
            idle(1);
            rd(FCS_OFF_STATUS, 8'ha0);
            wr(FCS_OFF_STATUS, 8'h20);
            rd(FCS_OFF_STATUS, 8'h80);
        end
        $display("test launch and access error done");
        @(posedge sys_clk);
        regRdStrobe <= 1'b0;
        seqWrite <= 1'b1;
        protectedTarget <= 1'b1;
        idle(1);
        protectedTarget <= 1'b0;
        rd(FCS_OFF_STATUS, 8'h90);
        seqWrite <= 1'b1;
        #1 chk({7'h00, seqAccept}, 8'h00, "sequence under violation");
        wr(FCS_OFF_STATUS, 8'h80);
        seqWrite <= 1'b0;
        #1 chk({7'h00, cmdLaunch}, 8'h00, "launch under violation");
        wr(FCS_OFF_STATUS, 8'($urandom()) & 8'h4f);
        rd(FCS_OFF_STATUS, 8'h90);
        wr(FCS_OFF_STATUS, 8'h10);
        rd(FCS_OFF_STATUS, 8'h80);
        seqWrite <= 1'b1;
        #1 chk({7'h00, seqAccept}, 8'h01, "sequence accepted");
        idle(1);
        $display("test protection done");
        wr(FCS_OFF_STATUS, 8'h80);
        rd(FCS_OFF_STATUS, 8'h08);
        execError <= 1'b1;
        idle(EXEC + 4);
        execError <= 1'b0;
        rd(FCS_OFF_STATUS, 8'h81);
        wr(FCS_OFF_STATUS, 8'h4f);
        rd(FCS_OFF_STATUS, 8'h81);
        wr(FCS_OFF_STATUS, 8'h80);
        idle(EXEC + 4);
        rd(FCS_OFF_STATUS, 8'h80);
        rd(FCS_OFF_IRQ_STAT, 8'h0f);
        idle(1);
        seqWrite <= 1'b0;
        @(posedge sys_clk);
        resetSeqDone <= 1'b1;
        resetSeqFault <= 1'b1;
        idle(1);
        rd(FCS_OFF_STATUS, 8'h83);
        $display("test result status done");
        wr(FCS_OFF_IRQ_STAT, 8'h0f);
        wr(FCS_OFF_CONFIG, 8'h80);
        idle(1);
        #1 chk({7'h00, irq}, 8'h01, "irq with enable");
        rd(FCS_OFF_CONFIG, 8'h80);
        wr(FCS_OFF_CONFIG, 8'h00);
        illegalCommand <= 1'b1;
        wr(FCS_OFF_IRQ_MASK, 8'h00);
        illegalCommand <= 1'b0;
        idle(1);
        #1 irqA = irq;
        wr(FCS_OFF_IRQ_MASK, 8'h0f);
        idle(1);
        #1 chk({7'h00, irqA ^ irq}, 8'h01, "mask gates irq");
        rd(FCS_OFF_IRQ_MASK, 8'h0f);
        wr(FCS_OFF_IRQ_STAT, 8'h0f);
        idle(1);
        #1 chk({7'h00, irq}, 8'h00, "irq after clear");
        idle(3);
        $display("test interrupts done");
        finish_test();
    end
endmodule // fcs_flash_command_status_tb
